// ---- verilog/iedr_pkg.sv ----
// Package of constants, states and state record for the input event diagnostic reporter
// Summary of operation
// - Process word flags edge inputs, bytes 2-3 zero
// - Diagnostic interrupts only under global enable
// - Repeat event during service raises incoming diagnostic
// - Other-channel events held during diagnostic service
// - Held diagnostics first, in order, then process
// - Affected channel's further process events discarded
// - Completed process service triggers outgoing diagnostic
// - Channel events between incoming and outgoing dropped
// - Outgoing message only if enable still set
// - Byte 0 carries failure and error flags
// - Byte 1 class 1111b plus channel flag
// - Byte 3 bit 6 lost; outgoing byte 3 zero
// - Extended record: basic four plus twelve bytes
// - Bytes 4-6 read 70h, 08h, 04h
// - Byte 7 flags faulty four-input channel group
// - Last diagnostic record kept when disabled
// - Process event only on configured input edge
`default_nettype none
package iedr_pkg;
    localparam int          NUM_CH        = 16;     // Input channels
    localparam int          CH_W          = 4;      // Channel index width
    localparam int          QUEUE_DEPTH   = 32;     // Two held events per channel
    localparam int          EVT_W         = 5;      // Queue entry: direction and channel
    localparam int          EVT_DIR_BIT   = 4;      // Entry bit set for outgoing
    localparam int          REC_W         = 128;    // Sixteen-byte record
    localparam int          INFO_W        = 32;     // Four-byte process word
    localparam int          B0_MOD_FAIL   = 0;      // Byte 0 module failure
    localparam int          B0_EXT_ERR    = 2;      // Byte 0 external error
    localparam int          B0_CH_ERR     = 3;      // Byte 0 channel error
    localparam int          B0_AUX_MISS   = 4;      // Byte 0 auxiliary supply missing
    localparam int          B1_CH_INFO    = 12;     // Byte 1 bit 4, record bit
    localparam int          B3_PI_LOST    = 30;     // Byte 3 bit 6, record bit
    localparam int          B1_CLASS_LSB  = 8;      // Byte 1 class field
    localparam int          B4_LSB        = 32;     // Byte 4 start
    localparam int          B5_LSB        = 40;     // Byte 5 start
    localparam int          B6_LSB        = 48;     // Byte 6 start
    localparam int          B7_LSB        = 56;     // Byte 7 group flags
    localparam int          B8_LSB        = 64;     // Byte 8 lost flags
    localparam int          GROUP_SIZE    = 4;      // Inputs per channel group
    localparam logic [3:0]  MOD_CLASS     = 4'hF;   // Digital module class
    localparam logic [6:0]  CH_TYPE       = 7'h70;  // Digital input channel type
    localparam logic [7:0]  DIAG_BITS     = 8'h08;  // Diagnostic bits per channel
    localparam logic [7:0]  CH_REPORTED   = 8'h04;  // Reported channel count

    // Service state, one-hot
    typedef enum logic [3:0] {
        SVC_IDLE    = 4'b0001,  // Nothing in service
        SVC_PI      = 4'b0010,  // Process handler running
        SVC_DIAG    = 4'b0100,  // Diagnostic handler running
        SVC_DIAG_PI = 4'b1000   // Diagnostic handler, process handler suspended
    } iedr_svc_t;

    // Whole state of the reporter
    typedef struct packed {
        logic             primed;    // Input history valid
        logic [NUM_CH-1:0] prev_in;  // Inputs one cycle ago
        logic [NUM_CH-1:0] pend_pi;  // Held process events
        logic [NUM_CH-1:0] svc_pi;   // Channels in the running process service
        logic [NUM_CH-1:0] diag_act; // Between incoming and outgoing
        logic [NUM_CH-1:0] inc_pend; // Incoming not yet queued
        logic [NUM_CH-1:0] out_pend; // Outgoing not yet queued
        iedr_svc_t        svc;       // Service state
        logic             pi_pulse;  // Process interrupt strobe
        logic             dg_pulse;  // Diagnostic interrupt strobe
        logic [INFO_W-1:0] pi_info;  // Process information word
        logic [REC_W-1:0] rec;       // Last diagnostic record
        logic             rec_out;   // Last record is outgoing
        logic [CH_W-1:0]  rec_ch;    // Channel of last record
    } iedr_state_t;
endpackage : iedr_pkg
`default_nettype wire

// ---- verilog/iedr_q_if.sv ----
// Interface between the reporter core and its held-event queue
`timescale 1ns/10ps
`default_nettype none
interface iedr_q_if #(parameter int WIDTH = 5) ();
    logic             push_valid; // Entry offered
    logic             push_ready; // Queue has room
    logic [WIDTH-1:0] push_data;  // Entry to store
    logic             pop_valid;  // Queue not empty
    logic             pop_ready;  // Head taken
    logic [WIDTH-1:0] pop_data;   // Head entry

    modport producer (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
    modport queue    (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
endinterface : iedr_q_if
`default_nettype wire

// ---- verilog/iedr_event_queue.sv ----
// Held diagnostic event queue, first in first out, flip-flop storage
`timescale 1ns/10ps
`default_nettype none
module iedr_event_queue #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 32
) (
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    iedr_q_if.queue   q
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    // Queue state
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;   // Storage
        logic [PW-1:0]               rd;    // Read index
        logic [PW-1:0]               wr;    // Write index
        logic [CW-1:0]               count; // Entries held
    } iedr_q_state_t;

    iedr_q_state_t st_r;  // Registered state
    iedr_q_state_t st_nxt; // Next state
    logic          do_push; // Write this cycle
    logic          do_pop;  // Read this cycle

    // Honest full and empty straight from the count
    assign q.push_ready = (st_r.count != CW'(DEPTH));
    assign q.pop_valid  = (st_r.count != '0);
    assign q.pop_data   = st_r.mem[st_r.rd];
    assign do_push      = q.push_valid && q.push_ready;
    assign do_pop       = q.pop_ready && q.pop_valid;

    // Next state; indices wrap explicitly so any depth works
    always_comb begin
        st_nxt = st_r;
        if (do_push) begin
            st_nxt.mem[st_r.wr] = q.push_data;
            st_nxt.wr = (st_r.wr == PW'(DEPTH - 1)) ? '0 : st_r.wr + 1'b1;
        end
        if (do_pop) begin
            st_nxt.rd = (st_r.rd == PW'(DEPTH - 1)) ? '0 : st_r.rd + 1'b1;
        end
        st_nxt.count = st_r.count + CW'(do_push) - CW'(do_pop);
    end

    // State register
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : iedr_event_queue
`default_nettype wire

// ---- verilog/iedr_top.sv ----
// Input event and diagnostic reporter: process word, diagnostic sequencing and records
`timescale 1ns/10ps
`default_nettype none
module iedr_top #(
    parameter int QDEPTH = iedr_pkg::QUEUE_DEPTH // Held-event queue depth
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_reset_n,
    input  wire logic [iedr_pkg::NUM_CH-1:0] i_inputs,      // Filtered input levels
    input  wire logic [iedr_pkg::NUM_CH-1:0] i_rise_sel,    // Rising edge raises event
    input  wire logic [iedr_pkg::NUM_CH-1:0] i_fall_sel,    // Falling edge raises event
    input  wire logic                        i_diag_int_en, // Global diagnostic enable
    input  wire logic                        i_module_fail, // Module failure flag
    input  wire logic                        i_ext_error,   // External error flag
    input  wire logic                        i_aux_missing, // Auxiliary supply missing
    input  wire logic                        i_proc_done,   // Process handler finished
    input  wire logic                        i_diag_done,   // Diagnostic handler finished
    output logic                             o_proc_int,    // Process interrupt strobe
    output logic [iedr_pkg::INFO_W-1:0]      o_proc_info,   // Process information word
    output logic                             o_diag_int,    // Diagnostic interrupt strobe
    output logic                             o_diag_outgoing, // Record is outgoing
    output logic [iedr_pkg::CH_W-1:0]        o_diag_channel,  // Record channel
    output logic [iedr_pkg::REC_W-1:0]       o_diag_record,   // Sixteen-byte record
    output logic                             o_diag_busy,     // Diagnostic handler active
    output logic                             o_proc_busy      // Process handler active or suspended
);
    iedr_pkg::iedr_state_t st_r;   // Registered state
    iedr_pkg::iedr_state_t st_nxt; // Next state

    logic [iedr_pkg::NUM_CH-1:0] edges;      // Configured edges this cycle
    logic                        pi_deliver; // Process interrupt issued now
    logic                        dg_pop;     // Queue head consumed now
    logic                        dg_fire;    // Diagnostic interrupt issued now
    logic [iedr_pkg::CH_W-1:0]   head_ch;    // Channel of queue head
    logic                        head_out;   // Queue head is outgoing

    iedr_q_if #(.WIDTH(iedr_pkg::EVT_W)) q ();

    // Lowest set bit of a channel vector
    function automatic logic [iedr_pkg::CH_W-1:0] iedr_lowest(input logic [iedr_pkg::NUM_CH-1:0] v);
        logic [iedr_pkg::CH_W-1:0] idx;
        idx = '0;
        for (int i = iedr_pkg::NUM_CH - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = iedr_pkg::CH_W'(i);
            end
        end
        return idx;
    endfunction : iedr_lowest

    // One-hot mask of a channel index
    function automatic logic [iedr_pkg::NUM_CH-1:0] iedr_mask(input logic [iedr_pkg::CH_W-1:0] ch);
        logic [iedr_pkg::NUM_CH-1:0] m;
        m = '0;
        m[ch] = 1'b1;
        return m;
    endfunction : iedr_mask

    // Build the sixteen-byte record; outgoing differs only in byte 3
    function automatic logic [iedr_pkg::REC_W-1:0] iedr_record(
        input logic [iedr_pkg::CH_W-1:0] ch,
        input logic                      outgoing,
        input logic                      fail,
        input logic                      ext,
        input logic                      aux
    );
        logic [iedr_pkg::REC_W-1:0] r;
        int                         c;
        r = '0;
        c = int'(ch);
        r[iedr_pkg::B0_MOD_FAIL] = fail;
        r[iedr_pkg::B0_EXT_ERR]  = ext;
        r[iedr_pkg::B0_CH_ERR]   = 1'b1;
        r[iedr_pkg::B0_AUX_MISS] = aux;
        r[iedr_pkg::B1_CLASS_LSB +: 4] = iedr_pkg::MOD_CLASS;
        r[iedr_pkg::B1_CH_INFO]  = 1'b1;
        r[iedr_pkg::B3_PI_LOST]  = !outgoing;
        r[iedr_pkg::B4_LSB +: 7] = iedr_pkg::CH_TYPE;
        r[iedr_pkg::B5_LSB +: 8] = iedr_pkg::DIAG_BITS;
        r[iedr_pkg::B6_LSB +: 8] = iedr_pkg::CH_REPORTED;
        r[iedr_pkg::B7_LSB + c / iedr_pkg::GROUP_SIZE] = 1'b1;
        r[iedr_pkg::B8_LSB + 8 * (c / iedr_pkg::GROUP_SIZE) + 2 * (c % iedr_pkg::GROUP_SIZE)] = 1'b1;
        return r;
    endfunction : iedr_record

    // Held events; depth covers one incoming and one outgoing per channel
    iedr_event_queue #(
        .WIDTH (iedr_pkg::EVT_W),
        .DEPTH (QDEPTH)
    ) u_queue (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .q         (q.queue)
    );

    // Configured edge detection; first cycle after reset only primes history
    always_comb begin
        edges = ((i_inputs & ~st_r.prev_in & i_rise_sel) |
                 (~i_inputs & st_r.prev_in & i_fall_sel)) & {iedr_pkg::NUM_CH{st_r.primed}};
    end

    assign head_ch  = q.pop_data[iedr_pkg::CH_W-1:0];
    assign head_out = q.pop_data[iedr_pkg::EVT_DIR_BIT];

    // Queue head is taken whenever no diagnostic service runs
    assign dg_pop = q.pop_valid && ((st_r.svc == iedr_pkg::SVC_IDLE) || (st_r.svc == iedr_pkg::SVC_PI));
    // Interrupt only while globally enabled; otherwise the record is still kept
    assign dg_fire = dg_pop && i_diag_int_en;
    // Process events wait until every held diagnostic has gone
    assign pi_deliver = (st_r.svc == iedr_pkg::SVC_IDLE) && !q.pop_valid &&
                        (st_r.inc_pend == '0) && (st_r.out_pend == '0) && (st_r.pend_pi != '0);

    // Queue feed: incoming first, then outgoing, one entry per cycle
    always_comb begin
        q.push_valid = (st_r.inc_pend != '0) || (st_r.out_pend != '0);
        if (st_r.inc_pend != '0) begin
            q.push_data = {1'b0, iedr_lowest(st_r.inc_pend)};
        end else begin
            q.push_data = {1'b1, iedr_lowest(st_r.out_pend)};
        end
        q.pop_ready = dg_pop;
    end

    // Next-state logic for the whole reporter
    always_comb begin
        st_nxt          = st_r;
        st_nxt.primed   = 1'b1;
        st_nxt.prev_in  = i_inputs;
        st_nxt.pi_pulse = 1'b0;
        st_nxt.dg_pulse = 1'b0;

        // Drain pending flags into the queue; a full queue stalls them
        if (q.push_valid && q.push_ready) begin
            if (st_r.inc_pend != '0) begin
                st_nxt.inc_pend = st_r.inc_pend & ~iedr_mask(iedr_lowest(st_r.inc_pend));
            end else begin
                st_nxt.out_pend = st_r.out_pend & ~iedr_mask(iedr_lowest(st_r.out_pend));
            end
        end

        // Diagnostic delivery from the queue head
        if (dg_pop) begin
            st_nxt.rec     = iedr_record(head_ch, head_out, i_module_fail, i_ext_error, i_aux_missing);
            st_nxt.rec_out = head_out;
            st_nxt.rec_ch  = head_ch;
            if (head_out) begin
                st_nxt.diag_act = st_nxt.diag_act & ~iedr_mask(head_ch);
            end
            if (dg_fire) begin
                st_nxt.dg_pulse = 1'b1;
                // Diagnostic service suspends a running process service
                st_nxt.svc = (st_r.svc == iedr_pkg::SVC_PI) ? iedr_pkg::SVC_DIAG_PI : iedr_pkg::SVC_DIAG;
            end
        end

        // Service completion
        unique case (st_r.svc)
            iedr_pkg::SVC_IDLE: begin
                if (pi_deliver) begin
                    st_nxt.pi_info  = {16'h0000, st_r.pend_pi};
                    st_nxt.svc_pi   = st_r.pend_pi;
                    st_nxt.pend_pi  = '0;
                    st_nxt.pi_pulse = 1'b1;
                    st_nxt.svc      = iedr_pkg::SVC_PI;
                end
            end
            iedr_pkg::SVC_PI: begin
                if (i_proc_done && !dg_fire) begin
                    // Channels that went diagnostic now report outgoing
                    st_nxt.out_pend = st_nxt.out_pend | (st_r.svc_pi & st_r.diag_act);
                    st_nxt.svc_pi   = '0;
                    st_nxt.svc      = iedr_pkg::SVC_IDLE;
                end
            end
            iedr_pkg::SVC_DIAG: begin
                if (i_diag_done) begin
                    st_nxt.svc = iedr_pkg::SVC_IDLE;
                end
            end
            iedr_pkg::SVC_DIAG_PI: begin
                if (i_diag_done) begin
                    st_nxt.svc = iedr_pkg::SVC_PI;
                end
            end
            default: begin
                st_nxt.svc = iedr_pkg::SVC_IDLE; // Illegal code recovers
            end
        endcase

        // Per-channel event sorting
        for (int c = 0; c < iedr_pkg::NUM_CH; c++) begin
            if (edges[c]) begin
                if (st_r.diag_act[c]) begin
                    // Dropped: channel sits between incoming and outgoing
                    st_nxt.pend_pi[c] = st_nxt.pend_pi[c];
                end else if (st_r.svc_pi[c]) begin
                    // Repeat while in service: process event lost
                    if (i_diag_int_en) begin
                        st_nxt.diag_act[c] = 1'b1;
                        st_nxt.inc_pend[c] = 1'b1;
                    end else begin
                        // Disabled: keep record readable, no interrupt
                        st_nxt.rec     = iedr_record(iedr_pkg::CH_W'(c), 1'b0, i_module_fail, i_ext_error,
                                                     i_aux_missing);
                        st_nxt.rec_out = 1'b0;
                        st_nxt.rec_ch  = iedr_pkg::CH_W'(c);
                    end
                end else begin
                    // Held until services allow delivery; set wins over clear
                    st_nxt.pend_pi[c] = 1'b1;
                end
            end
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_r     <= '0;
            st_r.svc <= iedr_pkg::SVC_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from state flops
    assign o_proc_int      = st_r.pi_pulse;
    assign o_proc_info     = st_r.pi_info;
    assign o_diag_int      = st_r.dg_pulse;
    assign o_diag_outgoing = st_r.rec_out;
    assign o_diag_channel  = st_r.rec_ch;
    assign o_diag_record   = st_r.rec;
    assign o_diag_busy     = (st_r.svc == iedr_pkg::SVC_DIAG) || (st_r.svc == iedr_pkg::SVC_DIAG_PI);
    assign o_proc_busy     = (st_r.svc == iedr_pkg::SVC_PI) || (st_r.svc == iedr_pkg::SVC_DIAG_PI);

    // Upper half of the process word is fixed zero
    AST_PI_INFO_HIGH_ZERO: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (o_proc_info[31:16] == 16'h0000) and (o_proc_int |-> o_proc_info[15:0] != 16'h0000))
        else $error("process word upper bytes or strobe content wrong");

    // No diagnostic strobe unless enabled one cycle before
    AST_DIAG_NEEDS_ENABLE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(o_diag_int) |-> $past(i_diag_int_en))
        else $error("diagnostic interrupt raised while disabled");

    // A repeat edge during service marks the channel diagnostic next cycle
    AST_REPEAT_MARKS: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (|(edges & st_r.svc_pi & ~st_r.diag_act) && i_diag_int_en) |=> ((|st_r.inc_pend) || q.pop_valid))
        else $error("lost process event did not queue a diagnostic");

    // Held process events only leave by delivery
    AST_HELD_KEPT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (|($past(st_r.pend_pi) & ~st_r.pend_pi)) |-> $past(pi_deliver))
        else $error("held process event vanished");

    // Process strobe never while diagnostics wait
    AST_DIAG_FIRST: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        pi_deliver |-> (!q.pop_valid && st_r.inc_pend == '0) ##1 o_proc_int)
        else $error("process interrupt overtook held diagnostic");

    // Edges on a diagnostic channel never become held events
    AST_DIAG_CH_DROPS: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (|(edges & st_r.diag_act & ~st_r.pend_pi)) |=>
            ((st_r.pend_pi & $past(edges & st_r.diag_act & ~st_r.pend_pi)) == '0))
        else $error("event of diagnostic channel was stored");

    // Fixed basic bytes of every record
    AST_BASIC_FIXED: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (o_diag_int |-> o_diag_record[23:8] == 16'h001F && o_diag_record[7:5] == 3'h0 && !o_diag_record[1]))
        else $error("record bytes 0 to 2 malformed");

    // Outgoing record byte 3 is zero, incoming carries the lost flag
    AST_BYTE3: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_diag_int |-> (o_diag_outgoing ? o_diag_record[31:24] == 8'h00 : o_diag_record[31:24] == 8'h40))
        else $error("record byte 3 wrong for direction");

    // Extended type bytes and zero tail
    AST_EXT_FIXED: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_diag_int |-> o_diag_record[55:32] == 24'h04_0870 && o_diag_record[127:96] == 32'h0000_0000)
        else $error("extended record constant bytes wrong");

    // Completed process service with diagnostic channels queues outgoing
    AST_OUT_AFTER_DONE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (st_r.svc == iedr_pkg::SVC_PI && i_proc_done && !dg_fire && |(st_r.svc_pi & st_r.diag_act)) |=>
            (st_r.out_pend != '0))
        else $error("outgoing diagnostic not scheduled");
endmodule : iedr_top
`default_nettype wire

// ---- verif/iedr_cpu_model.sv ----
// Controller model: ends handler services after a set delay and keeps the fault lamp
`timescale 1ns/10ps
`default_nettype none
module iedr_cpu_model (
    input  wire logic       i_clk,
    input  wire logic       i_proc_busy,
    input  wire logic       i_diag_busy,
    input  wire logic       i_diag_int,
    input  wire logic       i_outgoing,
    input  wire logic [7:0] i_delay,
    output logic            o_proc_done,
    output logic            o_diag_done,
    output logic            o_fault_led
);
    int cnt = 0;  // Cycles spent in the current service
    int open = 0; // Logged incoming events not yet closed by outgoing ones
    initial {o_proc_done, o_diag_done, o_fault_led} = 3'b000;
    // Done pulses only for the handler actually running; a suspended one waits
    always @(posedge i_clk) begin
        o_proc_done <= 1'b0;
        o_diag_done <= 1'b0;
        cnt <= ((i_proc_busy | i_diag_busy) & ~o_proc_done & ~o_diag_done) ? cnt + 1 : 0;
        if (cnt == int'(i_delay)) begin
            o_diag_done <= i_diag_busy;
            o_proc_done <= i_proc_busy & ~i_diag_busy;
        end
        if (i_diag_int === 1'b1) begin
            open = i_outgoing ? open - 1 : open + 1;
        end
        o_fault_led <= (open != 0);
    end
endmodule : iedr_cpu_model
`default_nettype wire

// ---- verif/iedr_top_tb.sv ----
// Self-checking bench for the input event diagnostic reporter
`timescale 1ns/10ps
`default_nettype none
module iedr_top_tb;
    logic i_clk = 0, i_reset_n = 0, en = 1, fail = 0, ext = 0, aux = 0;
    logic [15:0] inp = 0, fsel = 0, rsel = 16'hFFFF, seed = 16'h485E;
    logic [4:0] exp_q[$]; // Expected diagnostic order: direction bit and channel
    logic [7:0] dly = 8'h03; // Controller reaction time
    logic pdone, ddone, pi, di, dout, db, pb, led;
    logic [3:0] dch;
    logic [31:0] info;
    logic [127:0] rec;
    int failures = 0, num_checks = 0, n_pi = 0, n_di = 0, c;
    always #20 i_clk = ~i_clk;
    iedr_top iedr_top_i (.i_clk, .i_reset_n, .i_inputs(inp), .i_rise_sel(rsel), .i_fall_sel(fsel),
        .i_diag_int_en(en), .i_module_fail(fail), .i_ext_error(ext), .i_aux_missing(aux), .i_proc_done(pdone),
        .i_diag_done(ddone), .o_proc_int(pi), .o_proc_info(info), .o_diag_int(di), .o_diag_outgoing(dout),
        .o_diag_channel(dch), .o_diag_record(rec), .o_diag_busy(db), .o_proc_busy(pb));
    iedr_cpu_model iedr_cpu_model_i (.i_clk, .i_proc_busy(pb), .i_diag_busy(db), .i_diag_int(di),
        .i_outgoing(dout), .i_delay(dly), .o_proc_done(pdone), .o_diag_done(ddone), .o_fault_led(led));
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    // Reference record for channel ch, incoming or outgoing
    function automatic logic [127:0] exp_rec(input int ch, input bit o);
        logic [127:0] r = '0;
        r[7:0] = {3'b000, aux, 1'b1, ext, 1'b0, fail};
        r[15:8] = 8'h1F;
        r[31:24] = o ? 8'h00 : 8'h40;
        r[55:32] = 24'h04_0870;
        r[56 + ch / 4] = 1'b1;
        r[64 + 8 * (ch / 4) + 2 * (ch % 4)] = 1'b1;
        return r;
    endfunction : exp_rec
    task automatic check(input logic [127:0] seen, input logic [127:0] want);
        num_checks++;
        if (seen !== want) begin
            failures++;
            $display("Error at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    // Bounded wait for a process (d=0) or diagnostic (d=1) strobe
    task automatic wait_int(input bit d);
        int k;
        for (k = 0; k < 300; k++) begin
            @(posedge i_clk);
            #1;
            if ((d ? di : pi) === 1'b1) break;
        end
        if (k == 300) failures++;
    endtask : wait_int
    task automatic flip(input int ch);
        @(posedge i_clk);
        inp[ch] <= ~inp[ch];
    endtask : flip
    // Strobe counters; sampled before the edge's own updates land
    always @(posedge i_clk) begin
        n_pi += (pi === 1'b1);
        n_di += (di === 1'b1);
    end
    // Queue model: each diagnostic strobe must match the oldest expected event, in order
    always @(posedge i_clk) begin
        if (di === 1'b1) begin
            check({dout, dch}, (exp_q.size() > 0) ? exp_q.pop_front() : 'x);
        end
    end
    initial begin
        #(5000 * 40);
        failures++;
        complete_run();
    end
    initial begin
        seed = lfsr(seed);
        repeat (16) @(posedge i_clk);
        i_reset_n <= 1'b1;
        {aux, ext, fail} <= seed[2:0];
        repeat (3) @(posedge i_clk);
        flip(3);
        wait_int(0);
        check(info, 32'h0000_0008);
        repeat (8) @(posedge i_clk);
        flip(3); // Falling edge while only rising edges are selected
        repeat (8) @(posedge i_clk);
        check(n_pi, 1);
        rsel <= 16'h0000;
        flip(3); // Rising edge while rising selection is off
        repeat (8) @(posedge i_clk);
        check(n_pi, 1);
        fsel <= 16'hFFFF;
        rsel <= 16'hFFFF;
        dly <= 8'h1E;
        for (int p = 0; p < 2; p++) begin
            seed = lfsr(seed);
            c = seed[3:0];
            en <= (p == 0);
            if (p == 0) begin
                exp_q.push_back({1'b0, 4'(c)});
                exp_q.push_back({1'b1, 4'(c)});
            end
            flip(c);
            wait_int(0);
            check(info, 32'h1 << c);
            flip(c); // Repeat edge during service, then one that must vanish
            flip(c);
            if (p == 0) begin
                wait_int(1);
                check(di, 1'b1);
                check({db, pb}, 2'b11);
                check({dout, dch}, {1'b0, 4'(c)});
                check(rec, exp_rec(c, 0));
                wait_int(1);
                check(dout, 1'b1);
                check(rec, exp_rec(c, 1));
                check(led, 1'b1);
            end else begin
                repeat (10) @(posedge i_clk);
                check(rec, exp_rec(c, 0));
            end
            repeat (60) @(posedge i_clk);
        end
        check(n_pi, 3);
        check(n_di, 2);
        check(exp_q.size(), 0);
        complete_run();
    end
endmodule : iedr_top_tb
`default_nettype wire
